// ===== hdl/smc_filter.sv
`timescale 1ns/1ps
`default_nettype none
module smc_filter (
  smc_if.filt f
);
  logic blk_bc;
  logic blk_raw;
  logic blk_uc;

  always_comb begin
    blk_bc  = f.bcast & f.mode[smc_pkg::BIT_BCASTBLK];
    blk_uc  = f.mode[smc_pkg::BIT_MULTI] & f.mode[smc_pkg::BIT_OPT4] & f.unicast;
    blk_raw = (f.mode[smc_pkg::BIT_MULTI] & ~f.bcast & ~f.own_mac)
            | (f.mode[smc_pkg::BIT_OPT5] & f.mcast_mac)
            | (f.mode[smc_pkg::BIT_OPT4] & f.ipv6);
    // Options of other protocols are ignored
    if (smc_pkg::is_proto(f.mode, smc_pkg::PROTO_UDP)) begin
      f.accept = ~blk_bc & ~blk_uc;
    end else if (smc_pkg::is_proto(f.mode, smc_pkg::PROTO_RAW)) begin
      f.accept = ~blk_bc & ~blk_raw;
    end else if (smc_pkg::is_proto(f.mode, smc_pkg::PROTO_TCP)) begin
      f.accept = 1'b1;
    end else begin
      f.accept = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/smc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smc_if;
  logic [7:0] mode;
  logic       bcast;
  logic       mcast_mac;
  logic       own_mac;
  logic       ipv6;
  logic       unicast;
  logic       accept;
  modport top  (output mode, output bcast, output mcast_mac, output own_mac, output ipv6,
                output unicast, input accept);
  modport filt (input mode, input bcast, input mcast_mac, input own_mac, input ipv6,
                input unicast, output accept);
endinterface
`default_nettype wire

// ===== hdl/smc_pkg.sv
package smc_pkg;
  localparam logic [7:0] OFS_MODE      = 8'h00;
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam int         BIT_MULTI     = 7;
  localparam int         BIT_BCASTBLK  = 6;
  localparam int         BIT_OPT5      = 5;
  localparam int         BIT_OPT4      = 4;
  localparam logic [3:0] PROTO_CLOSED  = 4'h0;
  localparam logic [3:0] PROTO_TCP     = 4'h1;
  localparam logic [3:0] PROTO_UDP     = 4'h2;
  localparam logic [3:0] PROTO_RAW     = 4'h4;
  localparam logic [7:0] ST_CLOSED     = 8'h00;
  localparam logic [7:0] ST_TCP_READY  = 8'h13;
  localparam logic [7:0] ST_UDP_OPEN   = 8'h22;
  localparam logic [7:0] ST_RAW_OPEN   = 8'h02;
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         RETRY_UNIT_NS = 100000;
  localparam int         RETRY_UNIT_CYC = (RETRY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] TICK_LAST    = 12'(RETRY_UNIT_CYC - 1);

  function automatic logic is_proto(input logic [7:0] mode, input logic [3:0] code);
    return mode[3:0] == code;
  endfunction
endpackage

// ===== hdl/smc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - UDP bit 7 enables multicast
// - Raw bit 7 keeps broadcast and own MAC
// - UDP/raw bit 6 drops broadcast
// - TCP bit 5 acks at once
// - TCP bit 5 clear waits retry time
// - Multicast UDP bit 4 drops unicast
// - Raw bit 4 drops IPv6
// - Bits 3..0 select the protocol
// - Eight sockets, selected by 3-bit number
// - Open sets state per protocol
module smc_top #(
  parameter int SOCKETS = 8
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        HOST_WR,
  input  wire logic        HOST_RD,
  input  wire logic [2:0]  HOST_SEL,
  input  wire logic [7:0]  HOST_ADDR,
  input  wire logic [7:0]  HOST_WDATA,
  output logic      [7:0]  HOST_RDATA,
  output logic             HOST_RVALID,
  input  wire logic        OPEN_REQ,
  input  wire logic [2:0]  OPEN_SEL,
  output logic             STATE_VALID,
  output logic      [2:0]  STATE_SEL,
  output logic      [7:0]  STATE_CODE,
  input  wire logic        RX_VALID,
  input  wire logic [2:0]  RX_SEL,
  input  wire logic        RX_BCAST,
  input  wire logic        RX_MCAST_MAC,
  input  wire logic        RX_OWN_MAC,
  input  wire logic        RX_IPV6,
  input  wire logic        RX_UNICAST,
  output logic             RX_DONE,
  output logic             RX_ACCEPT,
  input  wire logic        ACK_SEG,
  input  wire logic [2:0]  ACK_SEL,
  input  wire logic [15:0] RETRY_TIME,
  output logic             ACK_SEND,
  output logic      [2:0]  ACK_SEND_SEL,
  output logic      [7:0]  MCAST_EN,
  output logic      [7:0]  IGMP_V1
);
  // Register file and host port
  logic [7:0] mode_r   [SOCKETS];
  logic [7:0] mode_nxt [SOCKETS];
  logic [7:0] rdata_r, rdata_nxt;
  logic       rvalid_r, rvalid_nxt;
  logic       hit_mode;

  always_comb begin
    hit_mode   = HOST_ADDR == smc_pkg::OFS_MODE;
    rvalid_nxt = HOST_RD;
    rdata_nxt  = 8'h00;
    for (int i = 0; i < SOCKETS; i++) begin
      mode_nxt[i] = mode_r[i];
    end
    if (HOST_WR && hit_mode) begin
      mode_nxt[HOST_SEL] = HOST_WDATA;
    end
    // Unmapped offsets read as zero
    if (HOST_RD && hit_mode) begin
      rdata_nxt = mode_r[HOST_SEL];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      for (int i = 0; i < SOCKETS; i++) begin
        mode_r[i] <= smc_pkg::RST_MODE;
      end
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      mode_r   <= mode_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Open command: state code from protocol field
  logic       stv_r, stv_nxt;
  logic [2:0] sts_r, sts_nxt;
  logic [7:0] stc_r, stc_nxt;

  always_comb begin
    stv_nxt = OPEN_REQ;
    sts_nxt = OPEN_REQ ? OPEN_SEL : sts_r;
    stc_nxt = stc_r;
    if (OPEN_REQ) begin
      case (mode_r[OPEN_SEL][3:0])
        smc_pkg::PROTO_TCP: stc_nxt = smc_pkg::ST_TCP_READY;
        smc_pkg::PROTO_UDP: stc_nxt = smc_pkg::ST_UDP_OPEN;
        smc_pkg::PROTO_RAW: stc_nxt = smc_pkg::ST_RAW_OPEN;
        // Closed and undefined patterns leave the socket closed
        default:            stc_nxt = smc_pkg::ST_CLOSED;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      stv_r <= 1'b0;
      sts_r <= 3'h0;
      stc_r <= smc_pkg::ST_CLOSED;
    end else begin
      stv_r <= stv_nxt;
      sts_r <= sts_nxt;
      stc_r <= stc_nxt;
    end
  end

  // Receive filter, one frame verdict per cycle
  smc_if fi ();
  assign fi.mode      = mode_r[RX_SEL];
  assign fi.bcast     = RX_BCAST;
  assign fi.mcast_mac = RX_MCAST_MAC;
  assign fi.own_mac   = RX_OWN_MAC;
  assign fi.ipv6      = RX_IPV6;
  assign fi.unicast   = RX_UNICAST;

  smc_filter u_filter (
    .f (fi)
  );

  logic rxd_r, rxd_nxt;
  logic rxa_r, rxa_nxt;

  always_comb begin
    rxd_nxt = RX_VALID;
    rxa_nxt = RX_VALID ? fi.accept : 1'b0;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      rxd_r <= 1'b0;
      rxa_r <= 1'b0;
    end else begin
      rxd_r <= rxd_nxt;
      rxa_r <= rxa_nxt;
    end
  end

  // Multicast flags per socket, UDP only
  logic [7:0] mc_r, mc_nxt;
  logic [7:0] igv_r, igv_nxt;

  always_comb begin
    mc_nxt  = 8'h00;
    igv_nxt = 8'h00;
    for (int i = 0; i < SOCKETS; i++) begin
      mc_nxt[i]  = smc_pkg::is_proto(mode_r[i], smc_pkg::PROTO_UDP)
                 & mode_r[i][smc_pkg::BIT_MULTI];
      igv_nxt[i] = mc_nxt[i] & mode_r[i][smc_pkg::BIT_OPT5];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      mc_r  <= 8'h00;
      igv_r <= 8'h00;
    end else begin
      mc_r  <= mc_nxt;
      igv_r <= igv_nxt;
    end
  end

  // Acknowledge scheduling; one ack covers all segments while pending
  logic [11:0] tdiv_r, tdiv_nxt;
  logic        tick;
  logic [SOCKETS-1:0] pend_r, pend_nxt;
  logic [16:0] cnt_r   [SOCKETS];
  logic [16:0] cnt_nxt [SOCKETS];
  logic        ack_r, ack_nxt;
  logic [2:0]  acks_r, acks_nxt;
  logic        found;

  always_comb begin
    tick     = tdiv_r == smc_pkg::TICK_LAST;
    tdiv_nxt = tick ? 12'h000 : tdiv_r + 12'h001;
    pend_nxt = pend_r;
    cnt_nxt  = cnt_r;
    ack_nxt  = 1'b0;
    acks_nxt = acks_r;
    found    = 1'b0;
    for (int i = 0; i < SOCKETS; i++) begin
      if (!smc_pkg::is_proto(mode_r[i], smc_pkg::PROTO_TCP)) begin
        pend_nxt[i] = 1'b0;
      end else if (pend_r[i] && cnt_r[i] == 17'h00000 && !found) begin
        found       = 1'b1;
        pend_nxt[i] = 1'b0;
        ack_nxt     = 1'b1;
        acks_nxt    = 3'(i);
      end else if (pend_r[i] && tick && cnt_r[i] != 17'h00000) begin
        cnt_nxt[i] = cnt_r[i] - 17'h00001;
      end
    end
    // A send in the same cycle still goes out; the new segment then re-arms the socket
    if (ACK_SEG && smc_pkg::is_proto(mode_r[ACK_SEL], smc_pkg::PROTO_TCP)) begin
      if (mode_r[ACK_SEL][smc_pkg::BIT_OPT5]) begin
        pend_nxt[ACK_SEL] = 1'b1;
        cnt_nxt[ACK_SEL]  = 17'h00000;
      end else if (!pend_r[ACK_SEL] || pend_nxt[ACK_SEL] == 1'b0) begin
        pend_nxt[ACK_SEL] = 1'b1;
        // One extra unit, as the free divider may tick right after arming
        cnt_nxt[ACK_SEL]  = (RETRY_TIME == 16'h0000) ? 17'h00000
                          : {1'b0, RETRY_TIME} + 17'h00001;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      tdiv_r <= 12'h000;
      pend_r <= '0;
      for (int i = 0; i < SOCKETS; i++) begin
        cnt_r[i] <= 17'h00000;
      end
      ack_r  <= 1'b0;
      acks_r <= 3'h0;
    end else begin
      tdiv_r <= tdiv_nxt;
      pend_r <= pend_nxt;
      cnt_r  <= cnt_nxt;
      ack_r  <= ack_nxt;
      acks_r <= acks_nxt;
    end
  end

  assign HOST_RDATA   = rdata_r;
  assign HOST_RVALID  = rvalid_r;
  assign STATE_VALID  = stv_r;
  assign STATE_SEL    = sts_r;
  assign STATE_CODE   = stc_r;
  assign RX_DONE      = rxd_r;
  assign RX_ACCEPT    = rxa_r;
  assign ACK_SEND     = ack_r;
  assign ACK_SEND_SEL = acks_r;
  assign MCAST_EN     = mc_r;
  assign IGMP_V1      = igv_r;
endmodule
`default_nettype wire

// ===== verif/smc_host.sv
`timescale 1ns/1ps
`default_nettype none
module smc_host (
  input  wire logic       SYS_CLK,
  input  wire logic [7:0] HOST_RDATA,
  output logic            HOST_WR = 1'b0,
  output logic            HOST_RD = 1'b0,
  output logic      [2:0] HOST_SEL = 3'h0,
  output logic      [7:0] HOST_ADDR = 8'h00,
  output logic      [7:0] HOST_WDATA = 8'h00
);
  // Idle cycle after each strobe, so no strobe is raised twice in one step
  task automatic wr(input logic [2:0] s, input logic [7:0] a, input logic [7:0] v);
    HOST_SEL = s;
    HOST_ADDR = a;
    HOST_WDATA = v;
    HOST_WR = 1'b1;
    @(negedge SYS_CLK);
    HOST_WR = 1'b0;
    HOST_WDATA = ~v;
    @(negedge SYS_CLK);
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] a, output logic [7:0] v);
    HOST_SEL = s;
    HOST_ADDR = a;
    HOST_RD = 1'b1;
    @(negedge SYS_CLK);
    HOST_RD = 1'b0;
    v = HOST_RDATA;
    @(negedge SYS_CLK);
  endtask
endmodule
`default_nettype wire

// ===== verif/smc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module smc_properties (
  input wire logic       SYS_CLK,
  input wire logic       RESETN,
  input wire logic       HOST_WR,
  input wire logic       HOST_RD,
  input wire logic [2:0] HOST_SEL,
  input wire logic [7:0] HOST_ADDR,
  input wire logic [7:0] HOST_WDATA,
  input wire logic [7:0] HOST_RDATA,
  input wire logic       HOST_RVALID,
  input wire logic       OPEN_REQ,
  input wire logic [2:0] OPEN_SEL,
  input wire logic       STATE_VALID,
  input wire logic [2:0] STATE_SEL,
  input wire logic [7:0] STATE_CODE,
  input wire logic       RX_VALID,
  input wire logic       RX_DONE,
  input wire logic       RX_ACCEPT,
  input wire logic       ACK_SEND,
  input wire logic [7:0] MCAST_EN,
  input wire logic [7:0] IGMP_V1
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  property p_rd_ans; HOST_RD |=> HOST_RVALID; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_idle; !HOST_RD |=> !HOST_RVALID && HOST_RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  // Write, idle, read of the same socket must return the written byte
  property p_rdback;
    HOST_WR && HOST_ADDR == 8'h00 ##1 !HOST_WR ##1 HOST_RD && HOST_ADDR == 8'h00 &&
      HOST_SEL == $past(HOST_SEL, 2) |=> HOST_RDATA == $past(HOST_WDATA, 3);
  endproperty
  a_rdback: assert property (p_rdback) else $error("mode readback differs");
  property p_open; OPEN_REQ |=> STATE_VALID && STATE_SEL == $past(OPEN_SEL); endproperty
  a_open: assert property (p_open) else $error("open not answered");
  property p_code; STATE_VALID |-> STATE_CODE inside {8'h00, 8'h13, 8'h22, 8'h02}; endproperty
  a_code: assert property (p_code) else $error("bad state code");
  property p_rx; RX_VALID |=> RX_DONE; endproperty
  a_rx: assert property (p_rx) else $error("frame verdict missing");
  property p_rx_idle; !RX_DONE |-> !RX_ACCEPT; endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("accept without verdict");
  property p_igmp; (IGMP_V1 & ~MCAST_EN) == 8'h00; endproperty
  a_igmp: assert property (p_igmp) else $error("igmp choice without multicast");
  c_ack: cover property (ACK_SEND);
  c_drop: cover property (RX_DONE && !RX_ACCEPT);
  c_udp: cover property (STATE_VALID && STATE_CODE == 8'h22);
endmodule
bind smc_top smc_properties u_props (.SYS_CLK, .RESETN, .HOST_WR, .HOST_RD, .HOST_SEL,
  .HOST_ADDR, .HOST_WDATA, .HOST_RDATA, .HOST_RVALID, .OPEN_REQ, .OPEN_SEL, .STATE_VALID,
  .STATE_SEL, .STATE_CODE, .RX_VALID, .RX_DONE, .RX_ACCEPT, .ACK_SEND, .MCAST_EN, .IGMP_V1);
`default_nettype wire

// ===== verif/socket_mode_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module socket_mode_config_bench;
  logic        SYS_CLK = 1'b0, RESETN = 1'b0, OPEN_REQ = 1'b0, RX_VALID = 1'b0, ACK_SEG = 1'b0;
  logic [2:0]  OPEN_SEL = 3'h0, RX_SEL = 3'h0, ACK_SEL = 3'h0, HOST_SEL, STATE_SEL, ACK_SEND_SEL;
  logic [4:0]  cls = 5'h00;
  logic [15:0] RETRY_TIME = 16'h0000;
  logic        HOST_WR, HOST_RD, HOST_RVALID, STATE_VALID, RX_DONE, RX_ACCEPT, ACK_SEND;
  logic [7:0]  HOST_ADDR, HOST_WDATA, HOST_RDATA, STATE_CODE, MCAST_EN, IGMP_V1, d;
  logic [7:0]  om [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h03};
  logic [7:0]  oc [5] = '{8'h00, 8'h13, 8'h22, 8'h02, 8'h00};
  // Mode, class {bcast, mcast_mac, own_mac, ipv6, unicast}, keep
  logic [13:0] rt [11] = '{{8'h42, 6'b100000}, {8'h02, 6'b100001}, {8'h92, 6'b000010},
    {8'h12, 6'b000011}, {8'h84, 6'b000000}, {8'h84, 6'b100001}, {8'h84, 6'b001001},
    {8'h24, 6'b010000}, {8'h14, 6'b000100}, {8'hF1, 6'b100111}, {8'h00, 6'b000010}};
  int          bad_count = 0, checks = 0, cyc = 0, n;
  smc_host h (.SYS_CLK, .HOST_RDATA, .HOST_WR, .HOST_RD, .HOST_SEL, .HOST_ADDR, .HOST_WDATA);
  smc_top dut (.SYS_CLK, .RESETN, .HOST_WR, .HOST_RD, .HOST_SEL, .HOST_ADDR, .HOST_WDATA,
    .HOST_RDATA, .HOST_RVALID, .OPEN_REQ, .OPEN_SEL, .STATE_VALID, .STATE_SEL, .STATE_CODE,
    .RX_VALID, .RX_SEL, .RX_BCAST(cls[4]), .RX_MCAST_MAC(cls[3]), .RX_OWN_MAC(cls[2]),
    .RX_IPV6(cls[1]), .RX_UNICAST(cls[0]), .RX_DONE, .RX_ACCEPT, .ACK_SEG, .ACK_SEL,
    .RETRY_TIME, .ACK_SEND, .ACK_SEND_SEL, .MCAST_EN, .IGMP_V1);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial forever #20 SYS_CLK = ~SYS_CLK;
  // Whole run is near 7500 cycles, the delayed ack dominating
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(negedge SYS_CLK);
    RESETN = 1'b1;
    @(negedge SYS_CLK);
    for (n = 0; n < 8; n++) begin
      h.rd(n[2:0], 8'h00, d);
      chk(d, 8'h00);
      h.wr(n[2:0], 8'h00, {1'b0, n[2:0], 4'h0});
      h.rd(n[2:0], 8'h00, d);
      chk(d, {1'b0, n[2:0], 4'h0});
    end
    h.wr(3'h0, 8'h01, 8'hFF);
    h.rd(3'h0, 8'h01, d);
    chk(d, 8'h00);
    for (n = 0; n < 8; n++) begin
      h.rd(n[2:0], 8'h00, d);
      chk(d, {1'b0, n[2:0], 4'h0});
    end
    // Sockets 0 to 2 in turn; raw mode lands on socket 0 only
    foreach (om[i]) begin
      h.wr(3'(i % 3), 8'h00, om[i]);
      OPEN_SEL = 3'(i % 3);
      OPEN_REQ = 1'b1;
      @(negedge SYS_CLK);
      OPEN_REQ = 1'b0;
      chk({STATE_VALID, STATE_SEL, STATE_CODE}, {1'b1, 3'(i % 3), oc[i]});
    end
    foreach (rt[i]) begin
      h.wr(3'h0, 8'h00, rt[i][13:6]);
      cls = rt[i][5:1];
      RX_VALID = 1'b1;
      @(negedge SYS_CLK);
      RX_VALID = 1'b0;
      chk({RX_DONE, RX_ACCEPT}, {1'b1, rt[i][0]});
    end
    h.wr(3'h5, 8'h00, 8'h82);
    chk({MCAST_EN, IGMP_V1}, 16'h2000);
    h.wr(3'h5, 8'h00, 8'hA2);
    chk({MCAST_EN, IGMP_V1}, 16'h2020);
    // Socket 0 is closed now, so only a true socket select keeps this frame
    RX_SEL = 3'h5;
    cls = 5'h01;
    RX_VALID = 1'b1;
    @(negedge SYS_CLK);
    RX_VALID = 1'b0;
    chk({RX_DONE, RX_ACCEPT}, 2'h3);
    h.wr(3'h5, 8'h00, 8'hA1);
    chk({MCAST_EN, IGMP_V1}, 16'h0000);
    h.wr(3'h1, 8'h00, 8'h21);
    ACK_SEL = 3'h1;
    ACK_SEG = 1'b1;
    @(negedge SYS_CLK);
    ACK_SEG = 1'b0;
    chk(ACK_SEND, 1'b0);
    @(negedge SYS_CLK);
    chk({ACK_SEND, ACK_SEND_SEL}, 4'h9);
    h.wr(3'h3, 8'h00, 8'h01);
    RETRY_TIME = 16'h0002;
    ACK_SEL = 3'h3;
    ACK_SEG = 1'b1;
    n = 0;
    do begin
      @(negedge SYS_CLK);
      ACK_SEG = 1'b0;
      n++;
    end while (ACK_SEND !== 1'b1 && n < 8000);
    chk(n >= 5000 && n <= 7502, 1'b1);
    chk(ACK_SEND_SEL, 3'h3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
